// >>> hw/deac_access_ctrl.sv
// Contract
// - Read start with data space selected yields the byte next instruction cycle.
// - Byte value holds after read until next read or firmware write.
// - Read start only settable by software; hardware clears it.
// - Data write needs select clear and permit set; address/data preloaded.
// - Write start accepted only if permit set by an earlier write.
// - Clearing permit during a running write does not abort it.
// - Key 55h then AAh, then write start, unlocks each byte write.
// - Write completion clears write start and sets done flag.
// - Control layout: select, zeros, abort, permit, write, read.
// - External or timeout reset mid-write sets abort; address/data survive.
// - Sixty-four bytes; upper two address bits ignored.
// - Write erases then programs; execution continues meanwhile.
// - Select clear targets data memory; set targets program memory.
`timescale 1ns/1ps
`default_nettype none

module deac_access_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cycleEn,
  // Special function register port
  input wire logic [8:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // System reset requests that abort a write
  input wire logic externalResetPin,
  input wire logic timeoutResetReq,
  // Completion flag kept here, cleared by firmware
  input wire logic writeDoneClear,
  output logic writeDoneFlag,
  output logic writeBusy
);
  import deac_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [MEM_ADDR_BITS-1:0] wrapAddr(
    input logic [7:0] addr
  );
    wrapAddr = addr[MEM_ADDR_BITS-1:0];
  endfunction

  // ==========================================================
  // Reset release and input synchronisers
  logic rstMeta;
  logic rstN;
  logic extMeta;
  logic extSync;
  logic wdtMeta;
  logic wdtSync;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      extMeta <= 1'b0;
      extSync <= 1'b0;
      wdtMeta <= 1'b0;
      wdtSync <= 1'b0;
    end else if (cycleEn) begin
      extMeta <= externalResetPin;
      extSync <= extMeta;
      wdtMeta <= timeoutResetReq;
      wdtSync <= wdtMeta;
    end
  end

  // ==========================================================
  // Registers
  logic select_reg;
  logic abort_reg;
  logic permit_reg;
  logic writeStart_reg;
  logic readStart_reg;
  logic writeDone_reg;
  logic [7:0] byteAddr_reg;
  logic [7:0] byteValue_reg;
  logic [MEM_ADDR_BITS-1:0] wrAddr_reg;
  logic [7:0] wrData_reg;
  logic [7:0] timer_reg;
  logic [7:0] memRdData;
  deac_key_type key_reg;
  deac_key_type key_next;
  deac_wr_type wr_reg;
  deac_wr_type wr_next;

  // ==========================================================
  // Decode
  wire sysReset = extSync | wdtSync;
  wire busy = wr_reg != WR_IDLE;
  wire ctlWrite = sfrWrite && (sfrAddr == CONTROL_OFFSET);
  wire keyWrite = sfrWrite && (sfrAddr == KEY_PORT_OFFSET);
  wire valWrite = sfrWrite && (sfrAddr == BYTE_VALUE_OFFSET);
  wire adrWrite = sfrWrite && (sfrAddr == BYTE_ADDRESS_OFFSET);
  wire keyFirst = keyWrite && (sfrWrData == UNLOCK_KEY_FIRST);
  wire keySecond = keyWrite && (sfrWrData == UNLOCK_KEY_SECOND);
  // Select may not change while an access is in flight
  wire selNow = (ctlWrite && !busy && !readStart_reg) ?
    sfrWrData[SELECT_BIT] : select_reg;
  // Only a one is taken; a zero write starts and clears nothing
  wire readGo = ctlWrite && sfrWrData[READ_START_BIT]
    && !selNow && !busy;
  // Permit is the value from an earlier write, never this one
  wire writeGo = ctlWrite && sfrWrData[WRITE_START_BIT]
    && permit_reg && (key_reg == KEY_ARMED)
    && !selNow && !busy;
  wire timerDone = timer_reg == 8'h00;
  wire eraseDone = (wr_reg == WR_ERASE) && timerDone;
  wire progDone = (wr_reg == WR_PROGRAM) && timerDone;

  // ==========================================================
  // Unlock sequence: any other register write breaks it
  always_comb begin
    key_next = KEY_IDLE;
    unique case (key_reg)
      KEY_IDLE: begin
        if (keyFirst) begin
          key_next = KEY_FIRST_SEEN;
        end
      end
      KEY_FIRST_SEEN: begin
        if (keySecond) begin
          key_next = KEY_ARMED;
        end else if (!sfrWrite) begin
          key_next = KEY_FIRST_SEEN;
        end
      end
      KEY_ARMED: begin
        if (!sfrWrite) begin
          key_next = KEY_ARMED;
        end else if (keyFirst) begin
          key_next = KEY_FIRST_SEEN;
        end
      end
    endcase
  end

  // ==========================================================
  // Write cycle sequencer
  always_comb begin
    wr_next = wr_reg;
    unique case (wr_reg)
      WR_IDLE: begin
        if (writeGo) begin
          wr_next = WR_ERASE;
        end
      end
      WR_ERASE: begin
        if (timerDone) begin
          wr_next = WR_PROGRAM;
        end
      end
      WR_PROGRAM: begin
        if (timerDone) begin
          wr_next = WR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      key_reg <= KEY_IDLE;
      wr_reg <= WR_IDLE;
      timer_reg <= 8'h00;
    end else if (cycleEn) begin
      if (sysReset) begin
        key_reg <= KEY_IDLE;
        wr_reg <= WR_IDLE;
        timer_reg <= 8'h00;
      end else begin
        key_reg <= key_next;
        wr_reg <= wr_next;
        if (writeGo) begin
          timer_reg <= ERASE_LAST;
        end else if (eraseDone) begin
          timer_reg <= PROGRAM_LAST;
        end else if (!timerDone) begin
          timer_reg <= timer_reg - 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Control bits; permit changes never touch a running write
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      select_reg <= SELECT_RESET;
      abort_reg <= ABORT_RESET;
      permit_reg <= PERMIT_RESET;
      writeStart_reg <= WRITE_START_RESET;
      readStart_reg <= READ_START_RESET;
    end else if (cycleEn) begin
      if (sysReset) begin
        // Select survives; the access bits return to zero
        permit_reg <= PERMIT_RESET;
        writeStart_reg <= WRITE_START_RESET;
        readStart_reg <= READ_START_RESET;
        if (busy) begin
          abort_reg <= 1'b1;
        end
      end else begin
        select_reg <= selNow;
        if (ctlWrite) begin
          abort_reg <= sfrWrData[ABORT_BIT];
          permit_reg <= sfrWrData[PERMIT_BIT];
        end
        if (writeGo) begin
          writeStart_reg <= 1'b1;
        end else if (progDone) begin
          writeStart_reg <= 1'b0;
        end
        readStart_reg <= readGo;
      end
    end
  end

  // ==========================================================
  // Completion flag: a set in the clear cycle wins
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      writeDone_reg <= 1'b0;
    end else if (cycleEn) begin
      if (progDone && !sysReset) begin
        writeDone_reg <= 1'b1;
      end else if (writeDoneClear) begin
        writeDone_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Address and data; a system reset leaves them alone
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      byteAddr_reg <= BYTE_ADDRESS_RESET;
      byteValue_reg <= BYTE_VALUE_RESET;
      wrAddr_reg <= '0;
      wrData_reg <= 8'h00;
    end else if (cycleEn) begin
      if (adrWrite) begin
        byteAddr_reg <= sfrWrData;
      end
      // Direct firmware writes take priority over read loads
      if (valWrite) begin
        byteValue_reg <= sfrWrData;
      end else if (readStart_reg) begin
        byteValue_reg <= memRdData;
      end
      if (writeGo) begin
        wrAddr_reg <= wrapAddr(byteAddr_reg);
        wrData_reg <= byteValue_reg;
      end
    end
  end

  // ==========================================================
  // Byte store; erase writes all ones, then the new value lands
  wire memWrEn = (eraseDone || progDone) && !sysReset;
  wire [7:0] memWrData = eraseDone ? ERASED_BYTE : wrData_reg;

  deac_byte_mem u_mem (
    .clk(core_clk),
    .clkEn(cycleEn),
    .rdEn(readGo),
    .rdAddr(wrapAddr(byteAddr_reg)),
    .rdData(memRdData),
    .write_permit(memWrEn),
    .wrAddr(wrAddr_reg),
    .wrData(memWrData)
  );

  // ==========================================================
  // Read back; the fresh byte is visible in the cycle after start
  wire [7:0] ctlRead = {select_reg, 3'b000, abort_reg, permit_reg,
    writeStart_reg, readStart_reg};
  wire [7:0] valRead = readStart_reg ? memRdData : byteValue_reg;

  always_comb begin
    unique case (sfrAddr)
      CONTROL_OFFSET: sfrRdData = ctlRead;
      BYTE_VALUE_OFFSET: sfrRdData = valRead;
      BYTE_ADDRESS_OFFSET: sfrRdData = byteAddr_reg;
      KEY_PORT_OFFSET: sfrRdData = 8'h00;
      default: sfrRdData = 8'h00;
    endcase
  end

  assign writeDoneFlag = writeDone_reg;
  assign writeBusy = busy;

endmodule

`default_nettype wire

// >>> hw/deac_pkg.sv
package deac_pkg;

  // ==========================================================
  // Special function register offsets
  localparam logic [8:0] CONTROL_OFFSET = 9'h18C;
  localparam logic [8:0] KEY_PORT_OFFSET = 9'h18D;
  localparam logic [8:0] BYTE_VALUE_OFFSET = 9'h10C;
  localparam logic [8:0] BYTE_ADDRESS_OFFSET = 9'h10D;

  // ==========================================================
  // Control register fields
  localparam int SELECT_BIT = 7;
  localparam int ABORT_BIT = 3;
  localparam int PERMIT_BIT = 2;
  localparam int WRITE_START_BIT = 1;
  localparam int READ_START_BIT = 0;
  localparam logic SELECT_RESET = 1'b0;
  localparam logic ABORT_RESET = 1'b0;
  localparam logic PERMIT_RESET = 1'b0;
  localparam logic WRITE_START_RESET = 1'b0;
  localparam logic READ_START_RESET = 1'b0;
  localparam logic [7:0] BYTE_VALUE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ADDRESS_RESET = 8'h00;

  // ==========================================================
  // Unlock keys and memory shape
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int MEM_ADDR_BITS = 6;
  localparam int MEM_BYTES = 64;

  // ==========================================================
  // Write timing at 25 MHz
  localparam int CLOCK_MHZ = 25;
  localparam int ERASE_TIME_US = 2;
  localparam int PROGRAM_TIME_US = 2;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLOCK_MHZ;
  localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLOCK_MHZ;
  localparam logic [7:0] ERASE_LAST =
    8'(ERASE_CYCLES - 1);
  localparam logic [7:0] PROGRAM_LAST =
    8'(PROGRAM_CYCLES - 1);

  // ==========================================================
  // State types
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_FIRST_SEEN,
    KEY_ARMED
  } deac_key_type;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_ERASE,
    WR_PROGRAM
  } deac_wr_type;

endpackage

// >>> hw/deac_byte_mem.sv
`timescale 1ns/1ps
`default_nettype none

module deac_byte_mem (
  // Clock
  input wire logic clk,
  input wire logic clkEn,
  // Read port
  input wire logic rdEn,
  input wire logic [deac_pkg::MEM_ADDR_BITS-1:0] rdAddr,
  output logic [7:0] rdData,
  // Write port
  input wire logic write_permit,
  input wire logic [deac_pkg::MEM_ADDR_BITS-1:0] wrAddr,
  input wire logic [7:0] wrData
);
  import deac_pkg::*;

  // ==========================================================
  // Storage; contents are not cleared by any reset
  logic [7:0] cells [MEM_BYTES];

  always_ff @(posedge clk) begin
    if (clkEn && write_permit) begin
      cells[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (clkEn && rdEn) begin
      rdData <= cells[rdAddr];
    end
  end

endmodule

`default_nettype wire

// >>> sim/deac_access_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module deac_access_ctrl_checker
  import deac_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cycleEn,
  // Register port
  input wire logic [8:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWrData,
  input wire logic [7:0] sfrRdData,
  // System resets and write status
  input wire logic externalResetPin,
  input wire logic timeoutResetReq,
  input wire logic writeDoneClear,
  input wire logic writeDoneFlag,
  input wire logic writeBusy
);
  localparam int WRITE_CYCLES = ERASE_CYCLES + PROGRAM_CYCLES;
  logic [1:0] keyStep_reg;
  logic [7:0] busyCount_reg;
  logic [2:0] quiet_reg;
  wire logic ctrlSel = sfrAddr == CONTROL_OFFSET;
  wire logic keySel = sfrAddr == KEY_PORT_OFFSET;
  wire logic quietNow = !externalResetPin && !timeoutResetReq;
  // Reset pins reach the core late, so demand a quiet history
  wire logic calm = quietNow && (&quiet_reg);
  wire logic startReq = sfrWrite && ctrlSel &&
    sfrWrData[WRITE_START_BIT] && !sfrWrData[SELECT_BIT];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Helper state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      keyStep_reg <= 2'h0;
      busyCount_reg <= 8'h00;
      quiet_reg <= 3'h7;
    end else if (cycleEn) begin
      quiet_reg <= {quiet_reg[1:0], quietNow};
      busyCount_reg <= writeBusy ? busyCount_reg + 8'h01 : 8'h00;
      if (sfrWrite) begin
        keyStep_reg <= (keySel && sfrWrData == UNLOCK_KEY_FIRST) ? 2'h1 :
          (keySel && sfrWrData == UNLOCK_KEY_SECOND &&
          keyStep_reg == 2'h1) ? 2'h2 : 2'h0;
      end
    end
  end
  // ==========================================================
  // Properties
  ctrl_zeros_a: assert property (ctrlSel |-> sfrRdData[6:4] == 3'h0)
    else $error("control unused bits not zero");
  key_port_a: assert property (keySel |-> sfrRdData == 8'h00)
    else $error("key port reads nonzero");
  start_mirror_a: assert property (ctrlSel |->
    sfrRdData[WRITE_START_BIT] == writeBusy)
    else $error("write start bit disagrees with busy");
  done_sticky_a: assert property (
    writeDoneFlag && !writeDoneClear |=> writeDoneFlag)
    else $error("done flag dropped without clear");
  done_cause_a: assert property ($rose(writeDoneFlag) |-> $fell(writeBusy))
    else $error("done flag set without write end");
  write_length_a: assert property ($fell(writeBusy) && $past(reset_n) &&
    calm |-> writeDoneFlag && busyCount_reg == WRITE_CYCLES)
    else $error("write length or completion wrong");
  write_bound_a: assert property (
    $rose(writeBusy) |-> ##[1:WRITE_CYCLES] !writeBusy)
    else $error("write ran too long");
  permit_clear_a: assert property (sfrWrite && ctrlSel && calm && writeBusy
    && busyCount_reg < 8'h62 |=> writeBusy)
    else $error("control write cut a write short");
  unlock_order_a: assert property ($rose(writeBusy) |->
    $past(keyStep_reg) == 2'h2 && $past(startReq))
    else $error("write began without unlock");
  same_write_a: assert property (sfrWrite && ctrlSel && !writeBusy &&
    !sfrRdData[PERMIT_BIT] |=> !writeBusy)
    else $error("write began with permit set in same write");
endmodule
bind deac_access_ctrl deac_access_ctrl_checker i_chk (
  .core_clk(core_clk), .reset_n(reset_n), .cycleEn(cycleEn),
  .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWrData(sfrWrData),
  .sfrRdData(sfrRdData), .externalResetPin(externalResetPin),
  .timeoutResetReq(timeoutResetReq), .writeDoneClear(writeDoneClear),
  .writeDoneFlag(writeDoneFlag), .writeBusy(writeBusy));
`default_nettype wire

// >>> sim/deac_access_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module deac_access_ctrl_bench;
  import deac_pkg::*;
  logic core_clk, reset_n, sfrWrite, extPin, toPin, doneClr;
  logic [8:0] sfrAddr;
  logic [7:0] sfrWrData;
  wire logic [7:0] sfrRdData;
  wire logic writeDoneFlag, writeBusy;
  int failures, checkCount;
  // Clock enable tied high: freezing is not exercised here
  deac_access_ctrl i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .cycleEn(1'b1), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
    .externalResetPin(extPin), .timeoutResetReq(toPin),
    .writeDoneClear(doneClr), .writeDoneFlag(writeDoneFlag),
    .writeBusy(writeBusy));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [7:0] e, g);
    checkCount++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrite = 1'b1;
    @(negedge core_clk);
    sfrWrite = 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    sfrAddr = a;
    #1;
    check($sformatf("reg %h", a), e, sfrRdData);
  endtask
  task automatic startWrite(input logic [7:0] a, d, p, k1, k2);
    wr(BYTE_ADDRESS_OFFSET, a);
    wr(BYTE_VALUE_OFFSET, d);
    wr(CONTROL_OFFSET, p);
    wr(KEY_PORT_OFFSET, k1);
    wr(KEY_PORT_OFFSET, k2);
    wr(CONTROL_OFFSET, 8'h06);
  endtask
  task automatic finishWrite;
    int n;
    n = 0;
    while (writeBusy !== 1'b0 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    check("done", 8'h01, {7'h00, writeDoneFlag});
    rd(CONTROL_OFFSET, {5'h00, sfrWrData[2], 2'h0});
    doneClr = 1'b1;
    @(negedge core_clk);
    doneClr = 1'b0;
    check("done clear", 8'h00, {7'h00, writeDoneFlag});
    wr(CONTROL_OFFSET, 8'h00);
  endtask
  task automatic readByte(input logic [7:0] a, e);
    wr(BYTE_VALUE_OFFSET, ~e);
    wr(BYTE_ADDRESS_OFFSET, a);
    wr(CONTROL_OFFSET, 8'h01);
    rd(BYTE_VALUE_OFFSET, e);
    rd(CONTROL_OFFSET, 8'h01);
    repeat (3) @(negedge core_clk);
    rd(CONTROL_OFFSET, 8'h00);
    rd(BYTE_VALUE_OFFSET, e);
  endtask
  // ==========================================================
  // Scenarios
  task automatic testLayout;
    rd(CONTROL_OFFSET, 8'h00);
    rd(KEY_PORT_OFFSET, 8'h00);
    wr(KEY_PORT_OFFSET, 8'h5A);
    rd(KEY_PORT_OFFSET, 8'h00);
    wr(CONTROL_OFFSET, 8'hF0);
    rd(CONTROL_OFFSET, 8'h80);
    wr(CONTROL_OFFSET, 8'h81);
    rd(CONTROL_OFFSET, 8'h80);
    wr(CONTROL_OFFSET, 8'h08);
    rd(CONTROL_OFFSET, 8'h08);
    wr(CONTROL_OFFSET, 8'h00);
    $display("test layout done");
  endtask
  task automatic testWrite;
    startWrite(8'h45, 8'h3C, 8'h04, UNLOCK_KEY_FIRST, UNLOCK_KEY_SECOND);
    rd(CONTROL_OFFSET, 8'h06);
    finishWrite();
    readByte(8'h05, 8'h3C);
    startWrite(8'h07, 8'hA5, 8'h04, UNLOCK_KEY_FIRST, UNLOCK_KEY_SECOND);
    wr(CONTROL_OFFSET, 8'h00);
    rd(CONTROL_OFFSET, 8'h02);
    finishWrite();
    readByte(8'h07, 8'hA5);
    $display("test write done");
  endtask
  task automatic testRefuse;
    logic [7:0] p [3] = '{8'h04, 8'h04, 8'h00};
    logic [7:0] k [3] = '{8'hAA, 8'h55, 8'h55};
    // Last pass keys correctly, so only the same-write permit refuses it
    logic [7:0] k2 [3] = '{8'h00, 8'hFF, 8'hAA};
    for (int i = 0; i < 3; i++) begin
      startWrite(8'h05, 8'h99, p[i], k[i], k2[i]);
      rd(CONTROL_OFFSET, 8'h04);
      check("busy", 8'h00, {7'h00, writeBusy});
      check("done", 8'h00, {7'h00, writeDoneFlag});
      wr(CONTROL_OFFSET, 8'h00);
    end
    readByte(8'h05, 8'h3C);
    $display("test refuse done");
  endtask
  task automatic testAbort;
    for (int i = 0; i < 2; i++) begin
      startWrite(8'h10, 8'h77, 8'h04, UNLOCK_KEY_FIRST, UNLOCK_KEY_SECOND);
      repeat (10) @(negedge core_clk);
      extPin = (i == 0);
      toPin = (i == 1);
      repeat (5) @(negedge core_clk);
      extPin = 1'b0;
      toPin = 1'b0;
      repeat (4) @(negedge core_clk);
      check("busy", 8'h00, {7'h00, writeBusy});
      check("done", 8'h00, {7'h00, writeDoneFlag});
      rd(CONTROL_OFFSET, 8'h08);
      rd(BYTE_ADDRESS_OFFSET, 8'h10);
      rd(BYTE_VALUE_OFFSET, 8'h77);
      wr(CONTROL_OFFSET, 8'h00);
    end
    $display("test abort done");
  endtask
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    endOfTest();
  end
  initial begin
    {reset_n, sfrWrite, extPin, toPin, doneClr} = 5'h00;
    sfrAddr = 9'h000;
    sfrWrData = 8'h00;
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    testLayout();
    testWrite();
    testRefuse();
    testAbort();
    endOfTest();
  end
endmodule
`default_nettype wire
